// [hw/cisc_core.sv]
// interrupt entry/return, stack pointer, z page register and 16-bit access temp byte
// assumes the sequencer pulses ins_done at each instruction end and stalls on busy_q
// Function
// - stack pointer is two bytes, low at base offset, high at base plus one
// - stack pointer resets to 0x10ff; bits 15..13 read zero, rest writable
// - io regs decode at data addresses and at port addresses plus 0x20; 0x60 up not here
// - extended loads and stores use page:zh:zl; plain load ignores page
// - low byte write goes to temp, high byte write copies temp to low
// - low byte read latches high byte into temp; high read returns temp
// - temp byte is directly readable and writable
// - two-operand alu result and flags written back in one cycle
// - interrupt needs its own enable and global enable both set
// - lowest vector wins; reset first, then source zero
// - vector select moves vectors to boot start; fuse moves reset vector
// - lock bits may suppress interrupts depending on program counter
// - global enable cleared on entry, set on return, writable for nesting
// - flags clear on vectoring and on software writing one
// - flags stay remembered while disabled, then served by priority
// - level sources request only while condition is present
// - one main instruction runs after return before any interrupt
// - clear-enable blocks at once; one instruction runs after set-enable
// - entry takes four cycles pushing pc, after current instruction ends
// - wake from sleep adds four cycles to entry
// - return takes four cycles, pops pc, sp plus two, sets enable
// - pushing a return address decrements stack pointer by two
// - global enable is status bit 7; status resets to zero
`timescale 1ns/1ps
`include "cisc_regs.svh"
module cisc_core import cisc_pkg::*; #(
  parameter int NSRC = 8,
  parameter logic [NSRC-1:0] FLAG_TYPE = '1,
  parameter int ZPAGE_BITS = 8,
  parameter logic [15:0] BOOT_START = 16'h7000,
  parameter logic [15:0] VEC_STEP = 16'h0002
) (
  input wire logic mclk,
  input wire logic rst,
  input wire cisc_io_req_s io_req,
  output logic [7:0] rdata_q,
  output logic rvalid_q,
  input wire logic ins_done,
  input wire logic ins_sei,
  input wire logic ins_cli,
  input wire logic ins_return_from_handler,
  input wire logic ins_call,
  input wire logic ins_ret,
  input wire logic ins_push,
  input wire logic ins_pop,
  input wire logic cpu_asleep,
  input wire logic [15:0] pc_now,
  input wire logic [NSRC-1:0] src_event,
  input wire logic [NSRC-1:0] src_level,
  input wire logic [NSRC-1:0] src_enable,
  input wire logic [NSRC-1:0] flag_clr_w1,
  input wire logic vector_select_bit,
  input wire logic boot_reset_fuse,
  input wire logic app_lock_bit,
  input wire logic boot_lock_bit,
  input wire logic prog_ext,
  input wire logic [7:0] z_high_byte,
  input wire logic [7:0] z_low_byte,
  input wire logic alu_go,
  input wire logic [2:0] alu_op,
  input wire logic [7:0] alu_a,
  input wire logic [7:0] alu_b,
  output logic [7:0] alu_res_q,
  output logic [23:0] prog_addr_q,
  output logic [15:0] reset_vec_q,
  output logic [NSRC-1:0] flags_q,
  output logic [7:0] status_register_q,
  output logic [15:0] stack_pointer_value_q,
  output logic busy_q,
  output logic stk_we_q,
  output logic stk_re_q,
  output logic [15:0] stk_addr_q,
  output logic [7:0] stk_wdata_q,
  input wire logic [7:0] stk_rdata,
  output logic pc_load_q,
  output logic [15:0] pc_value_q
);
  localparam logic [7:0] PAGE_MASK = 8'(({ZPAGE_BITS{1'b1}}));

  cisc_state_e state_q;
  logic [2:0] cnt_q;
  logic [2:0] len_q;
  logic [7:0] temp_q;
  logic [7:0] z_page_byte_q;
  logic hold_q;
  logic [7:0] addr_n;
  logic rd_spl, rd_sph, wr_spl, wr_sph;
  logic [NSRC-1:0] pend;
  logic [NSRC-1:0] win;
  logic suppress;
  logic take;
  logic gie;
  logic [15:0] vec_base;

  // lowest set bit as one-hot
  function automatic logic [NSRC-1:0] lowest(input logic [NSRC-1:0] v);
    return v & (~v + NSRC'(1));
  endfunction

  // one-hot to vector index
  function automatic logic [15:0] onehot_idx(input logic [NSRC-1:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < NSRC; i++) begin
      if (v[i]) begin
        r = 16'(i);
      end
    end
    return r;
  endfunction

  // port or data address to data space
  always_comb begin
    addr_n = io_req.port ? {2'b00, io_req.addr[5:0]} + `CISC_IO_BASE : io_req.addr;
  end

  assign rd_spl = io_req.rd && (addr_n == `CISC_OFS_SPL);
  assign rd_sph = io_req.rd && (addr_n == `CISC_OFS_SPH);
  assign wr_spl = io_req.wr && (addr_n == `CISC_OFS_SPL);
  assign wr_sph = io_req.wr && (addr_n == `CISC_OFS_SPH);
  assign gie = status_register_q[`CISC_GIE_BIT];

  // level sources join only while present
  assign pend = flags_q | (src_level & ~FLAG_TYPE);
  assign win = lowest(pend & src_enable);
  // lock bits block interrupts by pc section
  assign suppress = (app_lock_bit && !vector_select_bit && (pc_now >= BOOT_START)) ||
                    (boot_lock_bit && vector_select_bit && (pc_now < BOOT_START));
  // cli in the same cycle blocks the take
  assign take = (state_q == ST_IDLE) && (ins_done || cpu_asleep) && gie && !hold_q &&
                !ins_cli && (|win) && !suppress;
  assign vec_base = vector_select_bit ? BOOT_START : 16'h0000;

  // read data path
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= 1'b0;
      rdata_q <= 8'h00;
      if (io_req.rd) begin
        if (addr_n == `CISC_OFS_SPL) begin
          rdata_q <= stack_pointer_value_q[7:0];
          rvalid_q <= 1'b1;
        end else if (addr_n == `CISC_OFS_SPH) begin
          rdata_q <= temp_q;
          rvalid_q <= 1'b1;
        end else if (addr_n == `CISC_OFS_TEMP) begin
          rdata_q <= temp_q;
          rvalid_q <= 1'b1;
        end else if (addr_n == `CISC_OFS_ZPAGE) begin
          rdata_q <= z_page_byte_q & PAGE_MASK;
          rvalid_q <= 1'b1;
        end else if (addr_n == `CISC_OFS_STATUS_REGISTER) begin
          rdata_q <= status_register_q;
          rvalid_q <= 1'b1;
        end
      end
    end
  end

  // temp byte for 16-bit access
  always_ff @(posedge mclk) begin
    if (rst) begin
      temp_q <= 8'h00;
    end else if (rd_spl) begin
      // latch high byte on low read
      temp_q <= stack_pointer_value_q[15:8];
    end else if (wr_spl) begin
      temp_q <= io_req.wdata;
    end else if (io_req.wr && addr_n == `CISC_OFS_TEMP) begin
      temp_q <= io_req.wdata;
    end
  end

  // z page register and program address
  always_ff @(posedge mclk) begin
    if (rst) begin
      z_page_byte_q <= `CISC_RST_ZPAGE;
      prog_addr_q <= 24'h000000;
    end else begin
      if (io_req.wr && addr_n == `CISC_OFS_ZPAGE) begin
        z_page_byte_q <= io_req.wdata & PAGE_MASK;
      end
      // page only for extended load and store
      prog_addr_q <= {prog_ext ? z_page_byte_q & PAGE_MASK : 8'h00, z_high_byte, z_low_byte};
    end
  end

  // stack pointer
  always_ff @(posedge mclk) begin
    if (rst) begin
      stack_pointer_value_q <= `CISC_RST_SP;
    end else if (take || (state_q == ST_ENTER && cnt_q == 3'd0)) begin
      // one byte per push cycle, two per entry
      stack_pointer_value_q <= (stack_pointer_value_q - 16'h0001) & `CISC_SP_RW_MASK;
    end else if (state_q == ST_RET && cnt_q == 3'd1) begin
      stack_pointer_value_q <= (stack_pointer_value_q + 16'h0002) & `CISC_SP_RW_MASK;
    end else if (ins_call) begin
      stack_pointer_value_q <= (stack_pointer_value_q - 16'h0002) & `CISC_SP_RW_MASK;
    end else if (ins_ret) begin
      stack_pointer_value_q <= (stack_pointer_value_q + 16'h0002) & `CISC_SP_RW_MASK;
    end else if (ins_push) begin
      stack_pointer_value_q <= (stack_pointer_value_q - 16'h0001) & `CISC_SP_RW_MASK;
    end else if (ins_pop) begin
      stack_pointer_value_q <= (stack_pointer_value_q + 16'h0001) & `CISC_SP_RW_MASK;
    end else if (wr_sph) begin
      // high write copies temp into low
      // high byte at base plus one
      stack_pointer_value_q <= {io_req.wdata, temp_q} & `CISC_SP_RW_MASK;
    end
  end

  // status register and enable hold
  always_ff @(posedge mclk) begin
    if (rst) begin
      status_register_q <= `CISC_RST_STATUS_REGISTER;
      hold_q <= 1'b0;
      alu_res_q <= 8'h00;
    end else begin
      if (io_req.wr && addr_n == `CISC_OFS_STATUS_REGISTER) begin
        status_register_q <= io_req.wdata;
      end else if (alu_go) begin
        // result and flags in one cycle
        logic [8:0] r;
        r = 9'h000;
        case (alu_op)
          3'd0: r = {1'b0, alu_a} + {1'b0, alu_b};
          3'd1: r = {1'b0, alu_a} - {1'b0, alu_b};
          3'd2: r = {1'b0, alu_a & alu_b};
          3'd3: r = {1'b0, alu_a | alu_b};
          default: r = {1'b0, alu_a ^ alu_b};
        endcase
        alu_res_q <= r[7:0];
        status_register_q[2:0] <= {r[7], r[7:0] == 8'h00, r[8]};
      end
      if (take) begin
        status_register_q[`CISC_GIE_BIT] <= 1'b0;
      end else if (ins_cli) begin
        status_register_q[`CISC_GIE_BIT] <= 1'b0;
      end else if (ins_sei || (state_q == ST_RET && cnt_q == 3'd3)) begin
        status_register_q[`CISC_GIE_BIT] <= 1'b1;
      end
      if (ins_sei || (state_q == ST_RET && cnt_q == 3'd3)) begin
        hold_q <= 1'b1;
      end else if (ins_done) begin
        hold_q <= 1'b0;
      end
    end
  end

  // pending flags
  always_ff @(posedge mclk) begin
    if (rst) begin
      flags_q <= '0;
    end else begin
      // vectoring and write-one clear, set wins
      flags_q <= ((flags_q & ~flag_clr_w1 & ~(take ? win : '0)) | src_event) & FLAG_TYPE;
    end
  end

  // entry and return sequencer
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      cnt_q <= 3'd0;
      len_q <= 3'd0;
      busy_q <= 1'b0;
      stk_we_q <= 1'b0;
      stk_re_q <= 1'b0;
      stk_addr_q <= 16'h0000;
      stk_wdata_q <= 8'h00;
      pc_load_q <= 1'b0;
      pc_value_q <= 16'h0000;
      reset_vec_q <= 16'h0000;
    end else begin
      pc_load_q <= 1'b0;
      stk_we_q <= 1'b0;
      stk_re_q <= 1'b0;
      reset_vec_q <= boot_reset_fuse ? BOOT_START : 16'h0000;
      case (state_q)
        ST_IDLE: begin
          if (take) begin
            state_q <= ST_ENTER;
            busy_q <= 1'b1;
            cnt_q <= 3'd0;
            // wake adds cycles
            // last count of the entry; the sum is worked out wide enough for eight
            len_q <= cpu_asleep ? 3'(`CISC_ENTRY_CYC + `CISC_SLEEP_CYC - 4'd2) :
                     3'(`CISC_ENTRY_CYC - 3'd2);
            stk_we_q <= 1'b1;
            stk_addr_q <= stack_pointer_value_q;
            stk_wdata_q <= pc_now[7:0];
            pc_value_q <= vec_base + VEC_STEP * (onehot_idx(win) + 16'h0001);
          end else if (ins_return_from_handler && ins_done) begin
            state_q <= ST_RET;
            busy_q <= 1'b1;
            cnt_q <= 3'd0;
            stk_re_q <= 1'b1;
            stk_addr_q <= stack_pointer_value_q + 16'h0001;
          end
        end
        ST_ENTER: begin
          cnt_q <= cnt_q + 3'd1;
          if (cnt_q == 3'd0) begin
            stk_we_q <= 1'b1;
            stk_addr_q <= stack_pointer_value_q;
            stk_wdata_q <= pc_now[15:8];
          end
          if (cnt_q == len_q) begin
            pc_load_q <= 1'b1;
          end
          if (cnt_q == len_q) begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
          end
        end
        ST_RET: begin
          cnt_q <= cnt_q + 3'd1;
          if (cnt_q == 3'd0) begin
            stk_re_q <= 1'b1;
            stk_addr_q <= stack_pointer_value_q + 16'h0002;
          end else if (cnt_q == 3'd1) begin
            // read data stands the cycle after its strobe
            pc_value_q[15:8] <= stk_rdata;
          end else if (cnt_q == 3'd2) begin
            pc_value_q[7:0] <= stk_rdata;
            pc_load_q <= 1'b1;
          end else begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_sp_top_zero: assert property (stack_pointer_value_q[15:13] == 3'b000)
    else $error("stack pointer top bits set");
  a_temp_latch_high: assert property (rd_spl |=> temp_q == $past(stack_pointer_value_q[15:8]))
    else $error("temp did not latch high byte");
  a_sp_high_write: assert property (wr_sph && !take && !stk_we_q && state_q == ST_IDLE &&
    !ins_call && !ins_ret && !ins_push && !ins_pop |=>
    stack_pointer_value_q == ({$past(io_req.wdata), $past(temp_q)} & `CISC_SP_RW_MASK))
    else $error("high write did not join temp");
  a_take_needs_gie: assert property (take |-> gie && (|(win & src_enable)))
    else $error("take without enables");
  a_entry_clear_gie: assert property (take |=> !gie)
    else $error("global enable not cleared on entry");
  a_entry_pushes_two: assert property (take && !cpu_asleep |=>
    stk_we_q ##1 stk_we_q ##1 !stk_we_q ##0
    stack_pointer_value_q == (($past(stack_pointer_value_q, 3) - 16'h0002) & `CISC_SP_RW_MASK))
    else $error("entry did not push two bytes");
  a_entry_len_four: assert property (take && !cpu_asleep |=> busy_q [*3] ##1 !busy_q)
    else $error("entry length wrong");
  a_ret_len_four: assert property (state_q == ST_IDLE && ins_return_from_handler && ins_done && !take |=>
    busy_q [*4] ##1 (!busy_q && gie))
    else $error("return length or enable wrong");
  a_cli_blocks: assert property (ins_cli |-> !take)
    else $error("take beside cli");
  a_hold_after_sei: assert property (ins_sei && state_q == ST_IDLE |=> !take)
    else $error("take right after sei");
  a_flag_set_wins: assert property (|src_event |=> (flags_q & $past(src_event & FLAG_TYPE)) ==
    $past(src_event & FLAG_TYPE))
    else $error("flag set lost to clear");
  a_page_ignored: assert property (!prog_ext |=> prog_addr_q[23:16] == 8'h00)
    else $error("plain load used page");
  a_entry_len_sleep: assert property (take && cpu_asleep |=> busy_q [*7] ##1 !busy_q)
    else $error("wake entry length wrong");

  c_take: cover property (take ##[1:8] pc_load_q);
  c_wake: cover property (take && cpu_asleep);
  c_ret: cover property (state_q == ST_RET ##4 state_q == ST_IDLE);
  c_atomic_read: cover property (rd_spl ##1 rd_sph);
endmodule

// [include/cisc_regs.svh]
// register offsets, reset values and timing counts of the interrupt and stack control
// assumes data-space addressing; port addresses are mapped by adding the io window base
`ifndef CISC_REGS_SVH
`define CISC_REGS_SVH
`define CISC_IO_BASE 8'h20
`define CISC_IO_TOP 8'h3f
`define CISC_EXT_IO_BASE 8'h60
`define CISC_OFS_ZPAGE 8'h5b
`define CISC_OFS_TEMP 8'h5c
`define CISC_OFS_SPL 8'h5d
`define CISC_OFS_SPH 8'h5e
`define CISC_OFS_STATUS_REGISTER 8'h5f
`define CISC_RST_SP 16'h10ff
`define CISC_SP_RW_MASK 16'h1fff
`define CISC_RST_STATUS_REGISTER 8'h00
`define CISC_RST_ZPAGE 8'h00
`define CISC_GIE_BIT 7
`define CISC_ENTRY_CYC 3'd4
`define CISC_SLEEP_CYC 3'd4
`define CISC_RET_CYC 3'd4
`endif

// [include/cisc_pkg.sv]
// types shared by the interrupt and stack control
// assumes cisc_regs.svh supplies the numbers
package cisc_pkg;
  typedef struct packed {
    logic port;
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cisc_io_req_s;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ENTER = 3'b010,
    ST_RET = 3'b100
  } cisc_state_e;
endpackage

// [verification/cisc_stack_mem.sv]
// stack memory model that answers the stack push and pop strobes of the core
// assumes read data is wanted one cycle after the read strobe and is held for one cycle only
`timescale 1ns/1ps
module cisc_stack_mem (
  input wire logic mclk,
  input wire logic stk_we_q,
  input wire logic stk_re_q,
  input wire logic [15:0] stk_addr_q,
  input wire logic [7:0] stk_wdata_q,
  output logic [7:0] stk_rdata
);
  logic [7:0] mem [0:65535];
  initial begin
    stk_rdata = 8'h00;
  end
  // stored bytes return after one cycle, then the bus shows a changing pattern
  always @(posedge mclk) begin
    if (stk_we_q) begin
      mem[stk_addr_q] <= stk_wdata_q;
    end
    if (stk_re_q) begin
      stk_rdata <= mem[stk_addr_q];
    end else begin
      stk_rdata <= ~stk_rdata;
    end
  end
endmodule

// [verification/cpu_interrupt_stack_control_tb.sv]
// self-checking bench of the interrupt and stack control, one task per scenario
// assumes default core parameters but a level-type top source, and the stack memory model
`timescale 1ns/1ps
module cpu_interrupt_stack_control_tb import cisc_pkg::*;;
  logic mclk, rst, ins_done, ins_sei, ins_cli, ins_return_from_handler, ins_call, ins_ret, ins_push, ins_pop;
  logic cpu_asleep, vector_select_bit, boot_reset_fuse, app_lock_bit, boot_lock_bit, prog_ext;
  logic alu_go, rvalid_q, busy_q, stk_we_q, stk_re_q, pc_load_q;
  logic [2:0] alu_op;
  logic [7:0] alu_a, alu_b, alu_res_q, rdata_q, z_high_byte, z_low_byte, status_register_q;
  logic [7:0] src_event, src_level, src_enable, flag_clr_w1, flags_q, stk_wdata_q, stk_rdata;
  logic [15:0] pc_now, reset_vec_q, stack_pointer_value_q, stk_addr_q, pc_value_q, pcv;
  logic [23:0] prog_addr_q;
  cisc_io_req_s io_req;
  int error_cnt = 0;
  int check_count = 0;
  cisc_core #(.FLAG_TYPE(8'h7f)) i_dut (.mclk(mclk), .rst(rst), .io_req(io_req), .rdata_q(rdata_q),
    .rvalid_q(rvalid_q), .ins_done(ins_done), .ins_sei(ins_sei), .ins_cli(ins_cli),
    .ins_return_from_handler(ins_return_from_handler), .ins_call(ins_call), .ins_ret(ins_ret), .ins_push(ins_push),
    .ins_pop(ins_pop), .cpu_asleep(cpu_asleep), .pc_now(pc_now), .src_event(src_event),
    .src_level(src_level), .src_enable(src_enable), .flag_clr_w1(flag_clr_w1),
    .vector_select_bit(vector_select_bit), .boot_reset_fuse(boot_reset_fuse),
    .app_lock_bit(app_lock_bit), .boot_lock_bit(boot_lock_bit), .prog_ext(prog_ext),
    .z_high_byte(z_high_byte), .z_low_byte(z_low_byte), .alu_go(alu_go), .alu_op(alu_op),
    .alu_a(alu_a), .alu_b(alu_b), .alu_res_q(alu_res_q), .prog_addr_q(prog_addr_q),
    .reset_vec_q(reset_vec_q), .flags_q(flags_q), .status_register_q(status_register_q),
    .stack_pointer_value_q(stack_pointer_value_q), .busy_q(busy_q), .stk_we_q(stk_we_q),
    .stk_re_q(stk_re_q), .stk_addr_q(stk_addr_q), .stk_wdata_q(stk_wdata_q),
    .stk_rdata(stk_rdata), .pc_load_q(pc_load_q), .pc_value_q(pc_value_q));
  cisc_stack_mem i_mem (.mclk(mclk), .stk_we_q(stk_we_q), .stk_re_q(stk_re_q),
    .stk_addr_q(stk_addr_q), .stk_wdata_q(stk_wdata_q), .stk_rdata(stk_rdata));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    io_req = '{1'b0, 1'b0, 1'b1, a, d};
    @(negedge mclk);
    io_req = '0;
  endtask
  task automatic rd(input logic pt, input logic [7:0] a, input logic [8:0] exp);
    @(negedge mclk);
    io_req = '{pt, 1'b1, 1'b0, a, 8'h00};
    @(negedge mclk);
    io_req = '0;
    chk({15'h0, rvalid_q, rdata_q}, {15'h0, exp});
  endtask
  // one instruction end; returns the cycle at which a new pc was loaded, 0 if none
  task automatic instr(input logic s, input logic c, input logic r, output int n);
    @(negedge mclk);
    {ins_done, ins_sei, ins_cli, ins_return_from_handler} = {1'b1, s, c, r};
    @(negedge mclk);
    {ins_done, ins_sei, ins_cli, ins_return_from_handler} = 4'h0;
    n = 0;
    for (int i = 1; i <= 10; i++) begin
      if (pc_load_q === 1'b1 && n == 0) begin
        n = i;
        pcv = pc_value_q;
      end
      if (i < 10) @(negedge mclk);
    end
  endtask
  task automatic ev(input logic [7:0] m);
    @(negedge mclk);
    src_event = m;
    @(negedge mclk);
    src_event = 8'h00;
  endtask
  task automatic t_reset();
    chk(24'(stack_pointer_value_q), 24'h10ff);
    chk(24'(status_register_q), 24'h00);
    rd(1'b0, 8'h5d, 9'h1ff);
    rd(1'b0, 8'h5e, 9'h110);
  endtask
  task automatic t_sp16();
    wr(8'h5d, 8'h34);
    chk(24'(stack_pointer_value_q), 24'h10ff);
    wr(8'h5e, 8'hff);
    chk(24'(stack_pointer_value_q), 24'h1f34);
    rd(1'b0, 8'h5c, 9'h134);
    wr(8'h5c, 8'h56);
    wr(8'h5e, 8'h0f);
    chk(24'(stack_pointer_value_q), 24'h0f56);
    rd(1'b1, 8'h3d, 9'h156);
    rd(1'b0, 8'h5e, 9'h10f);
    rd(1'b0, 8'h60, 9'h000);
    wr(8'h5d, 8'h00);
    wr(8'h5e, 8'h08);
    @(negedge mclk);
    ins_call = 1'b1;
    @(negedge mclk);
    ins_call = 1'b0;
    chk(24'(stack_pointer_value_q), 24'h07fe);
    ins_ret = 1'b1;
    @(negedge mclk);
    ins_ret = 1'b0;
    chk(24'(stack_pointer_value_q), 24'h0800);
  endtask
  task automatic t_zpage_alu();
    logic [7:0] exp [5] = '{8'h10, 8'hd0, 8'h20, 8'hf0, 8'hd0};
    logic [2:0] flg [5] = '{3'h1, 3'h4, 3'h0, 3'h4, 3'h4};
    wr(8'h5b, 8'ha5);
    rd(1'b0, 8'h5b, 9'h1a5);
    {z_high_byte, z_low_byte, prog_ext} = {16'h1234, 1'b1};
    repeat (2) @(negedge mclk);
    chk(prog_addr_q, 24'ha51234);
    prog_ext = 1'b0;
    repeat (2) @(negedge mclk);
    chk(prog_addr_q, 24'h001234);
    for (int i = 0; i < 5; i++) begin
      {alu_go, alu_op, alu_a, alu_b} = {1'b1, 3'(i), 8'hf0, 8'h20};
      @(negedge mclk);
      alu_go = 1'b0;
      chk(24'(alu_res_q), 24'(exp[i]));
      chk(24'(status_register_q[2:0]), 24'(flg[i]));
      @(negedge mclk);
    end
  endtask
  task automatic t_irq();
    int n;
    pc_now = 16'h0123;
    src_enable = 8'h24;
    ev(8'h24);
    instr(1'b0, 1'b0, 1'b0, n);
    chk(24'(n), 24'd0);
    chk(24'(flags_q), 24'h24);
    src_enable = 8'h00;
    wr(8'h5f, 8'h85);
    instr(1'b0, 1'b0, 1'b0, n);
    chk(24'(n), 24'd0);
    src_enable = 8'h24;
    instr(1'b0, 1'b1, 1'b0, n);
    chk(24'(n), 24'd0);
    instr(1'b1, 1'b0, 1'b0, n);
    instr(1'b0, 1'b0, 1'b0, n);
    chk(24'(n), 24'd0);
    instr(1'b0, 1'b0, 1'b0, n);
    chk(24'(n), 24'd4);
    chk(24'(pcv), 24'h0006);
    chk(24'({status_register_q[7], flags_q}), 24'h020);
    chk(24'(status_register_q), 24'h05);
    chk(24'(stack_pointer_value_q), 24'h07fe);
    chk(24'({i_mem.mem[16'h0800], i_mem.mem[16'h07ff]}), 24'h2301);
    instr(1'b0, 1'b0, 1'b1, n);
    chk(24'(n), 24'd4);
    chk(24'(pcv), 24'h0123);
    chk(24'(stack_pointer_value_q), 24'h0800);
    chk(24'(status_register_q[7]), 24'd1);
    chk(24'(status_register_q), 24'h85);
    instr(1'b0, 1'b0, 1'b0, n);
    chk(24'(n), 24'd0);
    {app_lock_bit, pc_now} = {1'b1, 16'h7100};
    instr(1'b0, 1'b0, 1'b0, n);
    chk(24'(n), 24'd0);
    {app_lock_bit, pc_now, cpu_asleep} = {1'b0, 16'h0123, 1'b1};
    instr(1'b0, 1'b0, 1'b0, n);
    cpu_asleep = 1'b0;
    // the sleeping core is taken one edge before the strobe, so eight cycles count as seven
    chk(24'(n), 24'd7);
    chk({pcv, flags_q}, {16'h000c, 8'h00});
    // level source served only while present
    {src_level, src_enable} = {8'h80, 8'h00};
    wr(8'h5f, 8'h80);
    {src_level, src_enable} = {8'h00, 8'h80};
    instr(1'b0, 1'b0, 1'b0, n);
    chk(24'(n), 24'd0);
    src_level = 8'h80;
    instr(1'b0, 1'b0, 1'b0, n);
    src_level = 8'h00;
    chk({pcv, 8'(n)}, 24'h001004);
    ev(8'h02);
    flag_clr_w1 = 8'h02;
    @(negedge mclk);
    flag_clr_w1 = 8'h00;
    chk(24'(flags_q), 24'h00);
    {vector_select_bit, boot_reset_fuse, src_enable} = {2'b11, 8'h08};
    ev(8'h08);
    wr(8'h5f, 8'h80);
    instr(1'b0, 1'b0, 1'b0, n);
    chk({pcv, 8'(n)}, 24'h700804);
    chk(24'(reset_vec_q), 24'h7000);
  endtask
  task automatic summarize();
    if (error_cnt == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    {rst, ins_done, ins_sei, ins_cli, ins_return_from_handler, ins_call, ins_ret, ins_push, ins_pop} = 9'h100;
    {cpu_asleep, vector_select_bit, boot_reset_fuse, app_lock_bit, boot_lock_bit} = 5'h0;
    {prog_ext, alu_go, alu_op, alu_a, alu_b, z_high_byte, z_low_byte} = '0;
    {src_event, src_level, src_enable, flag_clr_w1, pc_now} = '0;
    io_req = '0;
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    t_reset();
    t_sp16();
    t_zpage_alu();
    t_irq();
    summarize();
  end
  initial begin
    #100000;
    error_cnt++;
    summarize();
  end
endmodule
